/* File: verilog/asc_ctrl.sv */
// Purpose: Sample, clamp and coefficient control of a single-channel scanner front end
// Assumes: MCLK and video strobe synchronous to CLK; registers over AHB-Lite
// Notes: Converted samples pass through a FIFO and leave as four nibbles, MSB first
// Notes on behaviour
// - Monochrome mode always applies the red coefficient set, never switching.
// - Colour mode lets the colour field pick red, green or blue set.
// - Colour code 00 red, 01 green, 10 blue, 11 reserved.
// - Three independent 8-bit offset and gain codes, all software writable.
// - Clamp pulse made from master clock and strobe only while enabled.
// - Clamp enable sampled on master clock rise inside each strobe pulse.
// - Clamp switch closed exactly while the clamp pulse is active.
// - Reset-sample position field places clamp, and in correlated mode the reset sample, in pixel.
// - Internal clamp converter code follows the 4-bit clamp code field.
// - Range bit selects alternate clamp converter range.
// - External reference bit disables internal clamp converter output.
// - Correlated bit, reset 1, picks sampled reset level as reference.
// - Non-correlated mode samples reference pin together with video sample.
// - Output delay field selects short, middle or long output timing.
// - Each sample is a 16-bit word sent on a 4-bit bus.
// - All configuration lives in registers written by the controller.
`timescale 1ns/10ps
module asc_ctrl #(
	parameter int SAMPLE_W = 16,
	parameter int NIBBLE_W = 4,
	parameter int DEPTH = asc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [asc_pkg::ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [asc_pkg::DATA_W-1:0] HWDATA,
	input wire logic HREADY,
	output logic [asc_pkg::DATA_W-1:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Timing inputs from the scanner controller
	input wire logic MCLK_IN,
	input wire logic VIDEO_SAMPLE_STROBE,
	// Converted sample in
	input wire logic ADC_VALID,
	output logic ADC_READY,
	input wire logic [SAMPLE_W-1:0] ADC_DATA,
	// Analogue control outputs
	output logic [7:0] OFFSET_CODE,
	output logic [7:0] GAIN_CODE,
	output logic CLAMP_PULSE,
	output logic CLAMP_SWITCH,
	output logic RESET_SAMPLE_CLK,
	output logic VIDEO_SAMPLE_CLK,
	output logic [3:0] CLAMP_CONVERTER_CODE,
	output logic CLAMP_CONVERTER_RANGE,
	output logic CLAMP_CONVERTER_EN,
	output logic REF_FROM_RESET_LEVEL,
	output logic [1:0] OUTPUT_DELAY_SEL,
	// Output nibble bus
	output logic [NIBBLE_W-1:0] OUTPUT_NIBBLE_BUS,
	output logic OUTPUT_NIBBLE_VALID
);
	import asc_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CLAMP = 3'b100
	} asc_state_t;

	function automatic logic [7:0] pick_code(input logic [1:0] sel, input logic [31:0] r,
		input logic [31:0] g, input logic [31:0] b, input int lo);
		logic [7:0] v;
		v = r[lo +: 8];
		case (sel)
			COL_GREEN: v = g[lo +: 8];
			COL_BLUE: v = b[lo +: 8];
			default: v = r[lo +: 8];
		endcase
		return v;
	endfunction : pick_code

	logic [31:0] ctrl_q, clamp_q, red_q, green_q, blue_q, rdata_d;
	logic [1:0] sel_q;
	logic wr_pend_q, addr_ok;
	logic [ADDR_W-1:0] wr_addr_q;

	// Bus: zero wait states, always OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else
		begin
			wr_pend_q <= addr_ok && HWRITE;
			wr_addr_q <= HADDR;
		end
	end

	// Configuration registers written by the controller
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ctrl_q <= CTRL_RESET;
			clamp_q <= CLAMP_RESET;
			red_q <= COEF_RESET;
			green_q <= COEF_RESET;
			blue_q <= COEF_RESET;
		end
		else if (wr_pend_q)
		begin
			case (wr_addr_q)
				OFS_CTRL: ctrl_q <= {24'h000000, HWDATA[7:0]};
				OFS_CLAMP: clamp_q <= {24'h000000, HWDATA[7:0]};
				OFS_RED: red_q <= {16'h0000, HWDATA[15:0]};
				OFS_GREEN: green_q <= {16'h0000, HWDATA[15:0]};
				OFS_BLUE: blue_q <= {16'h0000, HWDATA[15:0]};
				default: ;
			endcase
		end
	end

	// Coefficient selection; reserved code keeps last valid choice
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			sel_q <= COL_RED;
		else if (ctrl_q[CTRL_MONO])
			sel_q <= COL_RED;
		else if (ctrl_q[CTRL_COLOUR_LO +: 2] != 2'h3)
			sel_q <= ctrl_q[CTRL_COLOUR_LO +: 2];
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			OFFSET_CODE <= 8'h00;
			GAIN_CODE <= 8'h00;
		end
		else
		begin
			OFFSET_CODE <= pick_code(sel_q, red_q, green_q, blue_q, 0);
			GAIN_CODE <= pick_code(sel_q, red_q, green_q, blue_q, 8);
		end
	end

	// Clamp converter and reference control
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			CLAMP_CONVERTER_CODE <= 4'h0;
			CLAMP_CONVERTER_RANGE <= 1'b0;
			CLAMP_CONVERTER_EN <= 1'b1;
			REF_FROM_RESET_LEVEL <= 1'b1;
			OUTPUT_DELAY_SEL <= 2'h0;
		end
		else
		begin
			CLAMP_CONVERTER_CODE <= clamp_q[CLP_CODE_LO +: 4];
			CLAMP_CONVERTER_RANGE <= clamp_q[CLP_RANGE];
			CLAMP_CONVERTER_EN <= !clamp_q[CLP_EXT];
			REF_FROM_RESET_LEVEL <= ctrl_q[CTRL_CDS];
			OUTPUT_DELAY_SEL <= ctrl_q[CTRL_DLY_LO +: 2];
		end
	end

	// Master clock edge and strobe tracking
	logic mclk_q, strb_q, mclk_rise, strobe_fall, en_cap_q;
	logic [1:0] edge_cnt_q, len_q;
	asc_state_t st_q;
	assign mclk_rise = MCLK_IN && !mclk_q;
	assign strobe_fall = strb_q && !VIDEO_SAMPLE_STROBE;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mclk_q <= 1'b0;
			strb_q <= 1'b0;
		end
		else
		begin
			mclk_q <= MCLK_IN;
			strb_q <= VIDEO_SAMPLE_STROBE;
		end
	end

	// Decision captured once per strobe and held until the next
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			en_cap_q <= 1'b0;
		else if (mclk_rise && VIDEO_SAMPLE_STROBE)
			en_cap_q <= clamp_q[CLP_EN];
	end

	// Clamp placed a number of master clock edges after strobe end
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			st_q <= ST_IDLE;
			edge_cnt_q <= 2'h0;
			len_q <= 2'h0;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
					if (strobe_fall)
					begin
						st_q <= ST_WAIT;
						edge_cnt_q <= ctrl_q[CTRL_POS_LO +: 2];
					end
				ST_WAIT:
					if (mclk_rise)
					begin
						if (edge_cnt_q == 2'h0)
						begin
							st_q <= ST_CLAMP;
							len_q <= 2'(CLAMP_LEN - 1);
						end
						else
							edge_cnt_q <= edge_cnt_q - 2'h1;
					end
				ST_CLAMP:
					if (len_q == 2'h0)
						st_q <= ST_IDLE;
					else
						len_q <= len_q - 2'h1;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Reset sample comes every pixel in CORRELATED_SAMPLING_BIT; clamp only when enabled
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			CLAMP_PULSE <= 1'b0;
			CLAMP_SWITCH <= 1'b0;
			RESET_SAMPLE_CLK <= 1'b0;
			VIDEO_SAMPLE_CLK <= 1'b0;
		end
		else
		begin
			CLAMP_PULSE <= (st_q == ST_CLAMP) && en_cap_q;
			CLAMP_SWITCH <= (st_q == ST_CLAMP) && en_cap_q;
			VIDEO_SAMPLE_CLK <= mclk_rise && VIDEO_SAMPLE_STROBE;
			if (ctrl_q[CTRL_CDS])
				RESET_SAMPLE_CLK <= (st_q == ST_CLAMP);
			else
				RESET_SAMPLE_CLK <= mclk_rise && VIDEO_SAMPLE_STROBE;
		end
	end

	// Sample FIFO and nibble serialiser
	logic f_valid, f_ready;
	logic [SAMPLE_W-1:0] f_data;
	logic [SAMPLE_W-1:0] shift_q;
	logic [2:0] nib_left_q;
	logic [15:0] sample_cnt_q;
	assign f_ready = (nib_left_q == 3'h0);

	asc_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(CLK),
		.resetn(RESETN),
		.in_valid(ADC_VALID),
		.in_ready(ADC_READY),
		.in_data(ADC_DATA),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			shift_q <= '0;
			nib_left_q <= 3'h0;
			OUTPUT_NIBBLE_BUS <= '0;
			OUTPUT_NIBBLE_VALID <= 1'b0;
			sample_cnt_q <= 16'h0000;
		end
		else if (nib_left_q != 3'h0)
		begin
			OUTPUT_NIBBLE_BUS <= shift_q[SAMPLE_W-1 -: NIBBLE_W];
			OUTPUT_NIBBLE_VALID <= 1'b1;
			shift_q <= shift_q << NIBBLE_W;
			nib_left_q <= nib_left_q - 3'h1;
		end
		else
		begin
			OUTPUT_NIBBLE_VALID <= 1'b0;
			if (f_valid)
			begin
				shift_q <= f_data;
				nib_left_q <= 3'(SAMPLE_W / NIBBLE_W);
				sample_cnt_q <= sample_cnt_q + 16'h0001;
			end
		end
	end

	// Read decode, registered into the data phase
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (HADDR)
			OFS_CTRL: rdata_d = ctrl_q;
			OFS_CLAMP: rdata_d = clamp_q;
			OFS_RED: rdata_d = red_q;
			OFS_GREEN: rdata_d = green_q;
			OFS_BLUE: rdata_d = blue_q;
			OFS_STATUS: rdata_d = {26'h0, ADC_READY, f_valid, en_cap_q, CLAMP_PULSE, sel_q};
			OFS_SAMPLE: rdata_d = {16'h0000, sample_cnt_q};
			default: rdata_d = 32'h0000_0000;
		endcase
		// Forward a write still in its data phase so a back-to-back read sees the new value
		if (wr_pend_q && (wr_addr_q == HADDR) && (HADDR == OFS_CTRL || HADDR == OFS_CLAMP))
			rdata_d = {24'h000000, HWDATA[7:0]};
		else if (wr_pend_q && (wr_addr_q == HADDR) && (HADDR inside {OFS_RED, OFS_GREEN, OFS_BLUE}))
			rdata_d = {16'h0000, HWDATA[15:0]};
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			HRDATA <= 32'h0000_0000;
		else if (addr_ok && !HWRITE)
			HRDATA <= rdata_d;
	end

	// Checks
	property p_mono_red;
		ctrl_q[CTRL_MONO] |=> (sel_q == COL_RED);
	endproperty
	a_mono_red: assert property (p_mono_red) else $error("mono not red");
	property p_sel_follow;
		(!ctrl_q[CTRL_MONO] && ctrl_q[CTRL_COLOUR_LO +: 2] != 2'h3) |=> (sel_q == $past(ctrl_q[2:1]));
	endproperty
	a_sel_follow: assert property (p_sel_follow) else $error("colour select wrong");
	property p_rsv_hold;
		(!ctrl_q[CTRL_MONO] && ctrl_q[CTRL_COLOUR_LO +: 2] == 2'h3) |=> $stable(sel_q);
	endproperty
	a_rsv_hold: assert property (p_rsv_hold) else $error("reserved code changed selection");
	property p_no_clamp;
		!en_cap_q [*2] |-> !CLAMP_PULSE;
	endproperty
	a_no_clamp: assert property (p_no_clamp) else $error("clamp without enable");
	property p_switch;
		CLAMP_SWITCH == CLAMP_PULSE;
	endproperty
	a_switch: assert property (p_switch) else $error("switch differs from clamp");
	property p_hold_cap;
		!VIDEO_SAMPLE_STROBE |=> $stable(en_cap_q);
	endproperty
	a_hold_cap: assert property (p_hold_cap) else $error("decision changed outside strobe");
	property p_ext;
		clamp_q[CLP_EXT] |=> !CLAMP_CONVERTER_EN;
	endproperty
	a_ext: assert property (p_ext) else $error("converter on with external ref");
	property p_noncds;
		!ctrl_q[CTRL_CDS] |=> (RESET_SAMPLE_CLK == VIDEO_SAMPLE_CLK);
	endproperty
	a_noncds: assert property (p_noncds) else $error("reference not sampled with video");
	property p_nibbles;
		$rose(OUTPUT_NIBBLE_VALID) |-> OUTPUT_NIBBLE_VALID [*4];
	endproperty
	a_nibbles: assert property (p_nibbles) else $error("word not four nibbles");
	property p_ref_cds;
		REF_FROM_RESET_LEVEL == $past(ctrl_q[CTRL_CDS]);
	endproperty
	a_ref_cds: assert property (p_ref_cds) else $error("reference source differs from correlated bit");
	c_clamp: cover property (@(posedge CLK) disable iff (!RESETN) $rose(CLAMP_PULSE));
	c_blue: cover property (@(posedge CLK) disable iff (!RESETN) sel_q == COL_BLUE);
	c_full: cover property (@(posedge CLK) disable iff (!RESETN) !ADC_READY);
endmodule : asc_ctrl

/* File: inc/asc_pkg.sv */
// Purpose: Shared constants for the sample and clamp control block
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes: Register offsets are byte addresses
package asc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLAMP = 8'h04;
	localparam logic [7:0] OFS_RED = 8'h08;
	localparam logic [7:0] OFS_GREEN = 8'h0C;
	localparam logic [7:0] OFS_BLUE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SAMPLE = 8'h18;
	// Control register field positions
	localparam int CTRL_MONO = 0;
	localparam int CTRL_COLOUR_LO = 1;
	localparam int CTRL_CDS = 3;
	localparam int CTRL_POS_LO = 4;
	localparam int CTRL_DLY_LO = 6;
	// Clamp register field positions
	localparam int CLP_EN = 0;
	localparam int CLP_RANGE = 1;
	localparam int CLP_EXT = 2;
	localparam int CLP_CODE_LO = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
	localparam logic [31:0] CLAMP_RESET = 32'h0000_0000;
	localparam logic [31:0] COEF_RESET = 32'h0000_0000;
	localparam logic [1:0] COL_RED = 2'h0;
	localparam logic [1:0] COL_GREEN = 2'h1;
	localparam logic [1:0] COL_BLUE = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Clamp width, and correlated-mode reset-sample width, in clock cycles
	localparam int CLAMP_LEN = 2;
endpackage : asc_pkg

/* File: verilog/asc_fifo.sv */
// Purpose: Parameterised valid/ready FIFO
// Assumes: One clock, asynchronous active-low reset
// Notes: Full and empty are exact; no write when full
`timescale 1ns/10ps
module asc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_q];
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : asc_fifo

/* File: sim/asc_timing_src.sv */
// Purpose: Scanner timing controller model, drives master clock and sample strobe
// Assumes: Master clock derived from CLK with a half period of two or more cycles
// Notes: Both lines stand low while run is low, as a stopped controller leaves them
`timescale 1ns/10ps
module asc_timing_src (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic run,
	input wire logic [3:0] half,
	// Timing outputs
	output logic mclk,
	output logic strobe
);
	int cnt;
	int ph;
	// Strobe moves on the master clock fall so it is steady at every rise
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn || !run)
		begin
			cnt <= 0;
			ph <= 0;
			mclk <= 1'b0;
			strobe <= 1'b0;
		end
		else if (cnt + 1 >= int'(half))
		begin
			cnt <= 0;
			mclk <= ~mclk;
			if (mclk)
			begin
				ph <= (ph + 1) % 8;
				strobe <= (ph == 0);
			end
		end
		else
			cnt <= cnt + 1;
	end
endmodule : asc_timing_src

/* File: sim/asc_ctrl_tb.sv */
// Purpose: Self-checking bench for the sample and clamp control block
// Assumes: Zero-wait AHB-Lite slave, registered outputs
// Notes: Clamp placement is checked by relative delay, so fixed latency does not matter
`timescale 1ns/10ps
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module asc_ctrl_tb;
	import asc_pkg::*;
	logic clk, resetn, hsel, hwrite, run, mclk, vstb, av, ar, ov, cp, cs, rs, vs, ce, cr, rf, hro, hresp;
	logic pcp, pst, r1, cds_m;
	logic [7:0] haddr, oc, gc;
	logic [1:0] htrans, ds;
	logic [31:0] hwdata, hrdata, r, v;
	logic [15:0] ad, acc, exp_q[$], got_q[$];
	logic [3:0] half, ob, cc;
	int fail_count, cmp_count, cyc, fall_c, rises, hi_c, sw_bad, rs_bad, rs_c, nib, dly, pdly, n, refused, e;
	int coef[3];
	asc_ctrl u_asc_ctrl (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro), .HRDATA(hrdata), .HREADYOUT(hro),
		.HRESP(hresp), .MCLK_IN(mclk), .VIDEO_SAMPLE_STROBE(vstb), .ADC_VALID(av), .ADC_READY(ar),
		.ADC_DATA(ad), .OFFSET_CODE(oc), .GAIN_CODE(gc), .CLAMP_PULSE(cp), .CLAMP_SWITCH(cs),
		.RESET_SAMPLE_CLK(rs), .VIDEO_SAMPLE_CLK(vs), .CLAMP_CONVERTER_CODE(cc), .CLAMP_CONVERTER_RANGE(cr),
		.CLAMP_CONVERTER_EN(ce), .REF_FROM_RESET_LEVEL(rf), .OUTPUT_DELAY_SEL(ds),
		.OUTPUT_NIBBLE_BUS(ob), .OUTPUT_NIBBLE_VALID(ov));
	asc_timing_src u_asc_timing_src (.clk(clk), .resetn(resetn), .run(run), .half(half), .mclk(mclk),
		.strobe(vstb));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Outputs are looked at on the falling edge, well clear of the launch edge
	always @(negedge clk)
	begin
		cyc++;
		if (cs !== cp) sw_bad++;
		if (!cds_m && rs !== vs) rs_bad++;
		if (cds_m && rs !== cp) rs_bad++;
		if (rs === 1'b1) rs_c++;
		if (cp === 1'b1) hi_c++;
		if (pst && !vstb) fall_c = cyc;
		if (cp === 1'b1 && !pcp)
		begin
			rises++;
			dly = cyc - fall_c;
		end
		pcp = cp;
		pst = vstb;
		if (ov === 1'b1)
		begin
			acc = {acc[11:0], ob};
			nib++;
			if (nib == 4)
			begin
				got_q.push_back(acc);
				nib = 0;
			end
		end
	end
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hro !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hro !== 1'b1);
		r = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rck(input string nm, input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		`CHK(nm, x, r)
		`CHK("resp", 1'b0, hresp)
	endtask : rck
	task settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	initial
	begin
		#300000;
		fail_count++;
		close_out;
	end
	initial
	begin
		{resetn, hsel, hwrite, run, av, pcp, pst} = 7'h0;
		haddr = 8'h0;
		htrans = 2'h0;
		hwdata = 32'h0;
		ad = 16'h0;
		half = 4'h2;
		cds_m = 1'b1;
		e = 0;
		void'($urandom(32'h1541c13a));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rck("ctrl", OFS_CTRL, CTRL_RESET);
		rck("clamp", OFS_CLAMP, CLAMP_RESET);
		rck("unmapped", 8'h40, 32'h0);
		`CHK("ref", 1'b1, rf)
		for (int i = 0; i < 3; i++)
		begin
			coef[i] = $urandom & 16'hFFFF;
			wr(OFS_RED + 8'(4 * i), 32'(coef[i]));
			rck("coef", OFS_RED + 8'(4 * i), 32'(coef[i]));
		end
		// Codes 0 to 2, then the reserved code, then mono with blue asked for
		for (int k = 0; k < 5; k++)
		begin
			wr(OFS_CTRL, k < 4 ? 32'(8 | k << 1) : 32'hD);
			if (k < 3) e = k;
			settle;
			`CHK("offset", 8'(coef[k == 4 ? 0 : e]), oc)
			`CHK("gain", 8'(coef[k == 4 ? 0 : e] >> 8), gc)
		end
		$display("test coefficients done");
		cds_m = 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			wr(OFS_CTRL, 32'(k << 6));
			settle;
			`CHK("delay", 2'(k), ds)
			`CHK("ref", 1'b0, rf)
		end
		for (int k = 0; k < 4; k++)
		begin
			v = ($urandom & 32'hF0) | 32'(k << 1);
			wr(OFS_CLAMP, v);
			settle;
			`CHK("code", v[7:4], cc)
			`CHK("range", v[1], cr)
			`CHK("dac on", ~v[2], ce)
		end
		$display("test config done");
		for (int h = 2; h <= 5; h += 3)
		begin
			for (int p = 0; p < 4; p++)
			begin
				cds_m = (h == 5);
				wr(OFS_CTRL, 32'(p << 4 | (h == 5 ? 8 : 0)));
				wr(OFS_CLAMP, 32'h1);
				rises = 0;
				hi_c = 0;
				half <= 4'(h);
				run <= 1'b1;
				repeat (400) @(posedge clk);
				run <= 1'b0;
				repeat (50) @(posedge clk);
				`CHK("clamp on", 1'b1, rises > 0)
				`CHK("clamp len", CLAMP_LEN * rises, hi_c)
				if (p > 0) `CHK("position", 2 * h, dly - pdly)
				pdly = dly;
			end
		end
		cds_m = 1'b0;
		wr(OFS_CTRL, 32'h30);
		wr(OFS_CLAMP, 32'h0);
		rises = 0;
		run <= 1'b1;
		repeat (400) @(posedge clk);
		run <= 1'b0;
		repeat (50) @(posedge clk);
		`CHK("clamp off", 0, rises)
		`CHK("switch", 0, sw_bad)
		`CHK("ref sample", 0, rs_bad)
		`CHK("ref pulses", 1'b1, rs_c > 0)
		$display("test clamp done");
		n = 0;
		refused = 0;
		av <= 1'b1;
		ad <= 16'($urandom);
		for (int i = 0; i < 600 && n < 40; i++)
		begin
			@(negedge clk);
			r1 = ar;
			@(posedge clk);
			if (r1 === 1'b1)
			begin
				exp_q.push_back(ad);
				n++;
				ad <= 16'($urandom);
			end
			else
				refused++;
		end
		av <= 1'b0;
		for (int i = 0; i < 1000 && got_q.size() < 40; i++) @(posedge clk);
		`CHK("refusals", 1'b1, refused > 0)
		`CHK("words", 40, got_q.size())
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
			`CHK("word", exp_q[i], got_q[i])
		$display("test samples done");
		close_out;
	end
endmodule : asc_ctrl_tb
